// ===== rtl/mpbs_seq.sv
// Purpose: power-up, reset and boot source sequencing toward the carrier
// Assumes: inputs asynchronous, registers over APB
// Notes: all outputs come straight from flip-flops
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mpbs_seq
	import mpbs_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = MPBS_SETTLE_CYC // carrier settle time
) (
	input wire logic i_mclk, // system clock
	input wire logic i_rst, // async reset, high
	input wire logic i_input_power_bad_n, // input supply not good, low
	input wire logic i_reset_request_n, // carrier reset request, low
	input wire logic i_power_button_n, // power button, low
	input wire logic i_recovery_force_n, // force serial download, low
	input wire logic [2:0] i_boot_sel_n, // optional boot select lines
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction
	input wire logic [7:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error
	output logic o_internal_power_en, // module power circuits on
	output logic o_carrier_power_enable, // carrier supplies on, high
	output logic o_carrier_standby_n, // suspend indication, low
	output logic o_reset_out_n, // reset to carrier, low
	output logic o_boot_start, // boot start, one-cycle pulse
	output logic [2:0] o_boot_source // selected boot source
);
	mpbs_sync_if sif();
	logic pwr_bad_n;
	logic rst_req_n;
	logic btn_n;
	logic recov_n;
	mpbs_state_t state_ff;
	mpbs_state_t nxt_state;
	logic [MPBS_CNT_W-1:0] cnt_ff;
	logic btn_d_ff;
	logic btn_press;
	logic first_done_ff;
	logic sel_fit_ff;
	logic suspend_req_ff;
	logic shutdown_req_ff;
	logic [2:0] strap_ff;
	logic [2:0] bsel_ff;
	logic [2:0] nxt_boot;
	logic acc;
	logic addr_ok;

	////////////////////////////////////////////////////////////
	// input synchroniser
	assign sif.raw_n = {i_recovery_force_n, i_power_button_n, i_reset_request_n, i_input_power_bad_n};
	mpbs_sync u_sync (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.sif(sif)
	);
	assign pwr_bad_n = sif.sync_n[0];
	assign rst_req_n = sif.sync_n[1];
	assign btn_n = sif.sync_n[2];
	assign recov_n = sif.sync_n[3];

	// boot select lines are straps, sampled while reset is held in MPBS_ST_HOLD_RST
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			bsel_ff <= 3'h7;
		end else if (state_ff == MPBS_ST_HOLD_RST) begin
			bsel_ff <= i_boot_sel_n;
		end
	end

	// button press edge, falling on the synced level
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			btn_d_ff <= 1'b1;
		end else begin
			btn_d_ff <= btn_n;
		end
	end
	assign btn_press = btn_d_ff & ~btn_n;

	////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	assign acc = i_psel & i_penable;
	assign addr_ok = (i_paddr == MPBS_REG_CTRL) || (i_paddr == MPBS_REG_STAT) || (i_paddr == MPBS_REG_STRAP);

	// apb ready and error, answered in the access cycle
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & ~addr_ok;
		end
	end

	// control writes; sequencer clears one-shot requests it has taken
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			sel_fit_ff <= 1'b0;
			suspend_req_ff <= 1'b0;
			shutdown_req_ff <= 1'b0;
			strap_ff <= MPBS_STRAP_RST;
		end else begin
			if (state_ff != MPBS_ST_RUN) begin
				suspend_req_ff <= 1'b0;
				shutdown_req_ff <= 1'b0;
			end
			if (acc && o_pready && i_pwrite && i_paddr == MPBS_REG_CTRL) begin
				sel_fit_ff <= i_pwdata[MPBS_CTRL_SEL_FIT];
				suspend_req_ff <= i_pwdata[MPBS_CTRL_SUSPEND];
				shutdown_req_ff <= i_pwdata[MPBS_CTRL_SHUTDOWN];
			end
			if (acc && o_pready && i_pwrite && i_paddr == MPBS_REG_STRAP) begin
				strap_ff <= i_pwdata[2:0];
			end
		end
	end

	// read data, registered in the setup cycle
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_prdata <= 32'h0;
		end else if (i_psel && !i_penable && !i_pwrite) begin
			unique case (i_paddr)
				MPBS_REG_CTRL: o_prdata <= {29'h0, shutdown_req_ff, suspend_req_ff, sel_fit_ff};
				MPBS_REG_STAT: o_prdata <= {16'h0, 1'b0, o_boot_source, 1'b0, state_ff,
					4'h0, recov_n, btn_n, rst_req_n, pwr_bad_n};
				MPBS_REG_STRAP: o_prdata <= {29'h0, strap_ff};
				default: o_prdata <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// boot source decode
	always_comb begin
		nxt_boot = MPBS_BOOT_INVALID;
		if (!recov_n) begin
			nxt_boot = MPBS_BOOT_USB_DL;
		end else if (!sel_fit_ff) begin
			nxt_boot = strap_ff;
		end else begin
			// lines are high when bit set; column order 0,1,2
			unique case (bsel_ff)
				3'b000: nxt_boot = MPBS_BOOT_EMMC;
				3'b010: nxt_boot = MPBS_BOOT_CARRIER_SD;
				3'b110: nxt_boot = MPBS_BOOT_MICRO_SD;
				3'b001: nxt_boot = MPBS_BOOT_SPI_FLASH;
				default: nxt_boot = MPBS_BOOT_INVALID;
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			MPBS_ST_OFF: begin
				if (pwr_bad_n && !first_done_ff) begin
					nxt_state = MPBS_ST_PWR_INT;
				end
			end
			MPBS_ST_PWR_INT: begin
				if (!pwr_bad_n) begin
					nxt_state = MPBS_ST_OFF;
				end else begin
					nxt_state = MPBS_ST_CARRIER;
				end
			end
			MPBS_ST_CARRIER: begin
				if (!pwr_bad_n) begin
					nxt_state = MPBS_ST_OFF;
				end else if (cnt_ff >= MPBS_CNT_W'(SETTLE_CYC - 1)) begin
					nxt_state = MPBS_ST_HOLD_RST;
				end
			end
			MPBS_ST_HOLD_RST: begin
				if (!pwr_bad_n) begin
					nxt_state = MPBS_ST_OFF;
				end else if (rst_req_n) begin
					nxt_state = MPBS_ST_RUN;
				end
			end
			MPBS_ST_RUN: begin
				if (!pwr_bad_n) begin
					nxt_state = MPBS_ST_OFF;
				end else if (!rst_req_n) begin
					nxt_state = MPBS_ST_HOLD_RST;
				end else if (btn_press || shutdown_req_ff) begin
					nxt_state = MPBS_ST_SHUTDOWN;
				end else if (suspend_req_ff) begin
					nxt_state = MPBS_ST_STANDBY;
				end
			end
			MPBS_ST_STANDBY: begin
				if (!pwr_bad_n) begin
					nxt_state = MPBS_ST_OFF;
				end else if (!rst_req_n) begin
					nxt_state = MPBS_ST_HOLD_RST;
				end else if (btn_press) begin
					nxt_state = MPBS_ST_RUN;
				end
			end
			MPBS_ST_SHUTDOWN: begin
				if (!pwr_bad_n) begin
					nxt_state = MPBS_ST_OFF;
				end else if (btn_press) begin
					nxt_state = MPBS_ST_CARRIER;
				end
			end
			default: nxt_state = MPBS_ST_OFF;
		endcase
	end

	// state register
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= MPBS_ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// first power-on latch: a later drop only powers down
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			first_done_ff <= 1'b0;
		end else if (state_ff == MPBS_ST_PWR_INT && pwr_bad_n) begin
			first_done_ff <= 1'b1;
		end
	end

	// settle counter in the carrier state
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff <= '0;
		end else if (state_ff == MPBS_ST_CARRIER) begin
			cnt_ff <= cnt_ff + 1'b1;
		end else begin
			cnt_ff <= '0;
		end
	end

	////////////////////////////////////////////////////////////
	// outputs from flip-flops, driven by next state
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_internal_power_en <= 1'b0;
			o_carrier_power_enable <= 1'b0;
			o_carrier_standby_n <= 1'b0;
			o_reset_out_n <= 1'b0;
		end else begin
			o_internal_power_en <= pwr_bad_n && (nxt_state != MPBS_ST_OFF);
			o_carrier_power_enable <= nxt_state inside {MPBS_ST_CARRIER, MPBS_ST_HOLD_RST,
				MPBS_ST_RUN, MPBS_ST_STANDBY};
			o_carrier_standby_n <= nxt_state inside {MPBS_ST_CARRIER, MPBS_ST_HOLD_RST,
				MPBS_ST_RUN};
			o_reset_out_n <= (nxt_state == MPBS_ST_RUN) || (nxt_state == MPBS_ST_STANDBY);
		end
	end

	// boot start pulse and boot source capture on reset release
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_boot_start <= 1'b0;
			o_boot_source <= MPBS_BOOT_INVALID;
		end else begin
			o_boot_start <= (state_ff == MPBS_ST_HOLD_RST) && (nxt_state == MPBS_ST_RUN);
			if (state_ff == MPBS_ST_HOLD_RST && nxt_state == MPBS_ST_RUN) begin
				o_boot_source <= nxt_boot;
			end
		end
	end
endmodule : mpbs_seq
`default_nettype wire

// ===== rtl/mpbs_pkg.sv
// Purpose: constants and types shared by the module power and boot sequencer
// Assumes: i_mclk at 100 MHz, APB register access
// Notes: boot codes are the sequencer's own encoding of the selected boot source
//
// Behaviour
// - a low recovery force input selects serial download over the first USB port instead of a normal boot.
// - with no select lines fitted the boot source comes from fixed straps, by default the onboard micro SD.
// - fitted select lines decode LLL eMMC, LHL carrier SD, LHH onboard micro SD, HLL onboard SPI flash.
// - internal power is enabled only while the input power bad signal is not driven low.
// - the power-up sequence starts after the first application of input power and not on later events.
// - next, carrier power is enabled by asserting carrier power enable and carrier standby.
// - finally, only while reset request is not low, the reset output is released and boot starts.
// - carrier power enable is active high and switches on carrier supplies.
// - carrier standby is active low and signals suspend with application core power removed.
// - reset request low forces reset or reboot, and held low at power on postpones booting.
// - the reset output stays asserted during power-up so carrier power can settle, then deasserts.
// - the power button wakes the system from standby or shuts it down.
package mpbs_pkg;
	localparam int unsigned MPBS_CLK_MHZ = 100;
	localparam int unsigned MPBS_SETTLE_US = 10;
	localparam int unsigned MPBS_SETTLE_CYC = MPBS_SETTLE_US * MPBS_CLK_MHZ;
	localparam int unsigned MPBS_CNT_W = 16;
	localparam int unsigned MPBS_SYNC_N = 4;
	// apb register byte offsets
	localparam logic [7:0] MPBS_REG_CTRL = 8'h00;
	localparam logic [7:0] MPBS_REG_STAT = 8'h04;
	localparam logic [7:0] MPBS_REG_STRAP = 8'h08;
	// ctrl fields
	localparam int unsigned MPBS_CTRL_SEL_FIT = 0;
	localparam int unsigned MPBS_CTRL_SUSPEND = 1;
	localparam int unsigned MPBS_CTRL_SHUTDOWN = 2;
	// boot source codes
	typedef enum logic [2:0] {
		MPBS_BOOT_EMMC = 3'h0,
		MPBS_BOOT_CARRIER_SD = 3'h1,
		MPBS_BOOT_MICRO_SD = 3'h2,
		MPBS_BOOT_SPI_FLASH = 3'h3,
		MPBS_BOOT_USB_DL = 3'h4,
		MPBS_BOOT_INVALID = 3'h7
	} mpbs_boot_t;
	localparam logic [2:0] MPBS_STRAP_RST = 3'h2;
	// sequencer states
	typedef enum logic [2:0] {
		MPBS_ST_OFF = 3'h0,
		MPBS_ST_PWR_INT = 3'h1,
		MPBS_ST_CARRIER = 3'h2,
		MPBS_ST_HOLD_RST = 3'h3,
		MPBS_ST_RUN = 3'h4,
		MPBS_ST_STANDBY = 3'h5,
		MPBS_ST_SHUTDOWN = 3'h6
	} mpbs_state_t;
endpackage : mpbs_pkg

// ===== rtl/mpbs_sync_if.sv
// Purpose: carries synchronised control inputs from the synchroniser to the sequencer
// Assumes: one clock domain
// Notes: all signals keep their active-low sense
`timescale 1ns/1ps
`default_nettype none
interface mpbs_sync_if;
	logic [mpbs_pkg::MPBS_SYNC_N-1:0] raw_n;
	logic [mpbs_pkg::MPBS_SYNC_N-1:0] sync_n;
	modport src (input raw_n, output sync_n);
	modport dst (output raw_n, input sync_n);
endinterface : mpbs_sync_if
`default_nettype wire

// ===== rtl/mpbs_sync.sv
// Purpose: two-stage synchroniser for the low-active control inputs
// Assumes: inputs idle high, except input power bad, which reads bad until proven good
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module mpbs_sync
	import mpbs_pkg::*;
(
	input wire logic i_mclk, // system clock
	input wire logic i_rst, // async reset, high
	mpbs_sync_if.src sif // raw in, synced out
);
	logic [MPBS_SYNC_N-1:0] meta_ff;
	logic [MPBS_SYNC_N-1:0] sync_ff;
	// bit 0 is power bad: it resets to bad so that reset release cannot fake a good supply
	localparam logic [MPBS_SYNC_N-1:0] SYNC_RST = {{(MPBS_SYNC_N-1){1'b1}}, 1'b0};

	////////////////////////////////////////////////////////////
	// one generate loop, one chain per input
	genvar g;
	for (g = 0; g < MPBS_SYNC_N; g++) begin : g_bit
		always_ff @(posedge i_mclk or posedge i_rst) begin
			if (i_rst) begin
				meta_ff[g] <= SYNC_RST[g];
				sync_ff[g] <= SYNC_RST[g];
			end else begin
				meta_ff[g] <= sif.raw_n[g];
				sync_ff[g] <= meta_ff[g];
			end
		end
	end
	assign sif.sync_n = sync_ff;
endmodule : mpbs_sync
`default_nettype wire

// ===== test/mpbs_seq_asserts.sv
// Purpose: port checks for the power and boot sequencer
// Assumes: one clock, reset high
// Notes: bound to mpbs_seq
`timescale 1ns/1ps
`default_nettype none
module mpbs_seq_asserts
	import mpbs_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = MPBS_SETTLE_CYC // settle count
) (
	input wire logic i_mclk, // clock
	input wire logic i_rst, // reset
	input wire logic i_input_power_bad_n, // supply bad
	input wire logic i_reset_request_n, // reset request
	input wire logic i_recovery_force_n, // force download
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic [7:0] i_paddr, // apb address
	input wire logic o_pready, // apb ready
	input wire logic o_pslverr, // apb error
	input wire logic o_internal_power_en, // module power
	input wire logic o_carrier_power_enable, // carrier power
	input wire logic o_carrier_standby_n, // standby
	input wire logic o_reset_out_n, // reset out
	input wire logic o_boot_start, // boot pulse
	input wire logic [2:0] o_boot_source // boot source
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	////////////////////////////////
	// apb setup and a held download request
	sequence s_setup; i_psel && !i_penable; endsequence
	sequence s_recov; !i_recovery_force_n [*6]; endsequence
	property p_ready; s_setup |=> o_pready; endproperty
	a_ready: assert property (p_ready) else $error("apb answer missing");
	property p_unmap; s_setup ##0 (i_paddr > 8'h08) |=> o_pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not refused");
	property p_car; $rose(o_carrier_power_enable) |-> o_carrier_standby_n && o_internal_power_en; endproperty
	a_car: assert property (p_car) else $error("carrier step wrong");
	property p_rel; $rose(o_reset_out_n) |-> o_boot_start && $past(o_carrier_power_enable, SETTLE_CYC); endproperty
	a_rel: assert property (p_rel) else $error("reset release wrong");
	property p_pulse; o_boot_start |=> !o_boot_start; endproperty
	a_pulse: assert property (p_pulse) else $error("boot pulse long");
	property p_req; !i_reset_request_n [*6] |-> !o_reset_out_n; endproperty
	a_req: assert property (p_req) else $error("reset request ignored");
	property p_bad; !i_input_power_bad_n [*6] |-> !o_carrier_power_enable; endproperty
	a_bad: assert property (p_bad) else $error("power on while bad");
	property p_src; o_boot_start |=> o_boot_source != MPBS_BOOT_INVALID; endproperty
	a_src: assert property (p_src) else $error("no boot source");
	property p_recov; s_recov ##0 o_boot_start |=> o_boot_source == MPBS_BOOT_USB_DL; endproperty
	a_recov: assert property (p_recov) else $error("download not chosen");
endmodule : mpbs_seq_asserts
bind mpbs_seq mpbs_seq_asserts #(.SETTLE_CYC(SETTLE_CYC)) mpbs_seq_asserts_i (.*);
`default_nettype wire

// ===== test/mpbs_carrier.sv
// Purpose: carrier side model driving the control inputs
// Assumes: bench commands arrive at the clock edge
// Notes: STABLE_CYC sets how slow the supply is
`timescale 1ns/1ps
`default_nettype none
module mpbs_carrier #(
	parameter int STABLE_CYC = 8 // supply rise time
) (
	input wire logic i_mclk, // clock
	input wire logic i_supply_up, // supply applied
	input wire logic i_rst_req, // request reset
	input wire logic i_press, // button held
	input wire logic i_recov, // force download
	output logic o_input_power_bad_n = 1'b0, // supply bad
	output logic o_reset_request_n = 1'b1, // reset request
	output logic o_power_button_n = 1'b1, // button
	output logic o_recovery_force_n = 1'b1 // download
);
	int cnt = 0;
	////////////////////////////////
	// hold supply bad low until the supply has stood still
	always @(posedge i_mclk) begin
		cnt <= i_supply_up ? ((cnt < STABLE_CYC) ? cnt + 1 : cnt) : 0;
		o_input_power_bad_n <= i_supply_up && cnt >= STABLE_CYC;
	end
	// low-active control lines
	always @(posedge i_mclk) begin
		o_reset_request_n <= !i_rst_req;
		o_power_button_n <= !i_press;
		o_recovery_force_n <= !i_recov;
	end
endmodule : mpbs_carrier
`default_nettype wire

// ===== test/mpbs_seq_bench.sv
// Purpose: self-checking bench for the sequencer
// Assumes: short settle count
// Notes: apb tasks and carrier model drive all inputs except clock, reset and boot select lines
`timescale 1ns/1ps
`default_nettype none
module mpbs_seq_bench;
	import mpbs_pkg::*;
	logic i_mclk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic sup = 1'b0, req = 1'b0, prs = 1'b0, rcv = 1'b0, err;
	logic [2:0] i_boot_sel_n = 3'h0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
	logic i_input_power_bad_n, i_reset_request_n, i_power_button_n, i_recovery_force_n;
	logic o_pready, o_pslverr, o_internal_power_en, o_carrier_power_enable;
	logic o_carrier_standby_n, o_reset_out_n, o_boot_start;
	logic [2:0] o_boot_source;
	logic [2:0] sel [5] = '{3'h0, 3'h2, 3'h6, 3'h1, 3'h2};
	logic [2:0] src [5] = '{MPBS_BOOT_EMMC, MPBS_BOOT_CARRIER_SD, MPBS_BOOT_MICRO_SD, MPBS_BOOT_SPI_FLASH, MPBS_BOOT_USB_DL};
	int err_total = 0;
	int total_checks = 0;
	always #5 i_mclk = ~i_mclk;
	mpbs_carrier mpbs_carrier_i (.i_mclk(i_mclk), .i_supply_up(sup), .i_rst_req(req), .i_press(prs),
		.i_recov(rcv), .o_input_power_bad_n(i_input_power_bad_n), .o_reset_request_n(i_reset_request_n),
		.o_power_button_n(i_power_button_n), .o_recovery_force_n(i_recovery_force_n));
	mpbs_seq #(.SETTLE_CYC(4)) mpbs_seq_i (.*);
	////////////////////////////////
	task automatic report_and_stop;
		if (err_total == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk
	task automatic tk(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : tk
	// wait for reset out, carrier power or standby to reach v
	task automatic wait_for(input int k, input logic v);
		for (int n = 0; n < 300; n++) begin
			tk(1);
			if ((k == 0 ? o_reset_out_n : k == 1 ? o_carrier_power_enable : o_carrier_standby_n) === v)
				return;
		end
		chk(0, 1, "wait timeout");
		report_and_stop;
	endtask : wait_for
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
		@(posedge i_mclk);
		i_penable <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge i_mclk);
			if (o_pready === 1'b1) begin
				rd = o_prdata;
				err = o_pslverr;
				{i_psel, i_penable} <= 2'b00;
				return;
			end
		end
		chk(0, 1, "apb timeout");
		report_and_stop;
	endtask : apb
	task automatic press;
		@(posedge i_mclk);
		prs <= 1'b1;
		repeat (4) @(posedge i_mclk);
		prs <= 1'b0;
	endtask : press
	////////////////////////////////
	initial begin
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		tk(1);
		chk({o_internal_power_en, o_carrier_power_enable, o_reset_out_n, o_boot_source}, 6'h07, "reset outputs");
		apb(1'b0, MPBS_REG_STRAP, 32'h0);
		chk(rd, MPBS_BOOT_MICRO_SD, "strap reset");
		chk(err, 1'b0, "mapped error");
		apb(1'b1, 8'h0C, 32'h7);
		chk(err, 1'b1, "unmapped error");
		// power up while the carrier still asks for reset
		@(posedge i_mclk);
		{sup, req} <= 2'b11;
		tk(6);
		chk(o_carrier_power_enable, 1'b0, "early carrier");
		wait_for(1, 1'b1);
		chk({o_internal_power_en, o_carrier_standby_n}, 2'b11, "carrier step");
		tk(20);
		chk(o_reset_out_n, 1'b0, "boot postponed");
		@(posedge i_mclk);
		req <= 1'b0;
		wait_for(0, 1'b1);
		chk(o_boot_start, 1'b1, "boot pulse");
		tk(1);
		chk(o_boot_source, MPBS_BOOT_MICRO_SD, "strap boot");
		// reboot through the four decoded select codes, then forced download
		apb(1'b1, MPBS_REG_CTRL, 32'h1);
		for (int t = 0; t < 5; t++) begin
			@(posedge i_mclk);
			{i_boot_sel_n, rcv, req} <= {sel[t], t == 4, 1'b1};
			tk(8);
			chk(o_reset_out_n, 1'b0, "reboot hold");
			@(posedge i_mclk);
			req <= 1'b0;
			wait_for(0, 1'b1);
			tk(1);
			chk(o_boot_source, src[t], "boot source");
		end
		rcv <= 1'b0;
		// suspend keeps carrier power, button wakes
		apb(1'b1, MPBS_REG_CTRL, 32'h3);
		wait_for(2, 1'b0);
		chk(o_carrier_power_enable, 1'b1, "suspend carrier");
		press();
		wait_for(2, 1'b1);
		chk(o_reset_out_n, 1'b1, "wake");
		// button shuts down and powers up again
		press();
		wait_for(1, 1'b0);
		chk(o_carrier_standby_n, 1'b0, "shutdown");
		press();
		wait_for(0, 1'b1);
		// supply loss turns off for good
		@(posedge i_mclk);
		sup <= 1'b0;
		wait_for(1, 1'b0);
		chk(o_internal_power_en, 1'b0, "power loss");
		@(posedge i_mclk);
		sup <= 1'b1;
		tk(30);
		chk(o_carrier_power_enable, 1'b0, "single power up");
		report_and_stop;
	end
endmodule : mpbs_seq_bench
`default_nettype wire
